// >>> common/timer_link_pkg.sv
package timer_link_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [19:0] OUTPUT_MODE_SELECT_ADDR = 20'hF01BE;
  localparam logic [19:0] OUTPUT_POLARITY_ADDR = 20'hF01C0;
  localparam logic [19:0] OUTPUT_ENABLE_ADDR = 20'hF01C2;
  localparam logic [19:0] INPUT_FILTER_ENABLE_ADDR = 20'hF01C4;
  localparam logic [19:0] START_TRIGGER_ADDR = 20'hF01C6;
  localparam logic [19:0] STOP_TRIGGER_ADDR = 20'hF01C8;
  localparam logic [19:0] ACTIVE_STATUS_ADDR = 20'hF01CA;
  localparam logic [19:0] MODE_BASE_ADDR = 20'hF01D0;
  localparam logic [19:0] OUTPUT_LEVEL_ADDR = 20'hF01E0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] OUTPUT_MODE_SELECT_RST = 16'h0000;
  localparam logic [7:0] INPUT_FILTER_ENABLE_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CLOCK_SELECT_HIGH_POS = 15;
  localparam int CLOCK_SELECT_LOW_POS = 14;
  localparam int COUNT_SOURCE_POS = 12;
  localparam int SPLIT_BYTE_POS = 11;
  localparam int START_INT_OPTION_POS = 0;
  localparam int UPPER_CH1_POS = 9;
  localparam int UPPER_CH3_POS = 11;
  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam int FILTER_STABLE_CYCLES = 2;
endpackage : timer_link_pkg

// >>> rtl/timer_link.sv
// Functional notes
// RULE1: polarity bit 1 inverts channel output, 0 keeps it active high.
// RULE2: polarity change takes effect at the next output change only.
// RULE3: mode bit 0 toggles output on each own-channel interrupt.
// RULE4: mode bit 1 sets on master interrupt, resets on own interrupt.
// RULE5: new mode applies only at a set/reset event while output enabled.
// RULE6: filter on: synchronise, accept level stable for two clocks.
// RULE7: filter off: synchronise only, no stability check.
// RULE8: one filter enable bit per input pin, 1 means on.
// RULE9: software makes only even channels masters.
// RULE10: slaves above their master, never channel 0, several allowed.
// RULE11: no other master between a slave and its master.
// RULE12: slave clock select bits equal the master's.
// RULE13: master signals go only upward; slaves forward nothing.
// RULE14: linked channels start with one simultaneous write.
// RULE15: no retrigger of slave channels alone while counting.
// RULE16: linked channels stop with one simultaneous write.
// RULE17: no auxiliary prescaler clocks during simultaneous operation.
// RULE18: split 8-bit mode only on channels 1 and 3, via split bit.
// RULE19: upper half is interval only, interrupts at start.
// RULE20: upper half uses lower clock select, own start/stop/status bits.
// RULE21: in 16-bit mode upper start/stop ignored, status unchanged.
// RULE22: no simultaneous functions on split channels.
// RULE23: count source bit picks operation clock or input edges.
`timescale 1ns/1ps
module timer_link
  import timer_link_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // register port
  input wire logic [timer_link_pkg::ADDR_W-1:0] i_addr,
  input wire logic [timer_link_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [timer_link_pkg::DATA_W-1:0] o_rdata,
  // timer core events
  input wire logic [timer_link_pkg::NUM_CH-1:0] i_channel_interrupt,
  input wire logic [timer_link_pkg::NUM_CH-1:0] i_master_sel,
  input wire logic [3:0] i_op_clock_tick,
  // pins
  input wire logic [timer_link_pkg::NUM_CH-1:0] i_timer_input_pin,
  output logic [timer_link_pkg::NUM_CH-1:0] o_timer_out,
  // to counters
  output logic [timer_link_pkg::NUM_CH-1:0] o_count_clock,
  output logic [timer_link_pkg::NUM_CH-1:0] o_start_pulse,
  output logic [timer_link_pkg::NUM_CH-1:0] o_stop_pulse,
  output logic [timer_link_pkg::NUM_CH-1:0] o_active,
  output logic [1:0] o_upper_active,
  output logic [1:0] o_upper_tick,
  output logic [1:0] o_upper_start_irq
);
  import timer_link_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] mode_sel_q, mode_sel_d, pol_q, pol_d, oen_q, oen_d;
  logic [7:0] filt_en_q, filt_en_d;
  logic [15:0] chmode_q [NUM_CH];
  logic [15:0] chmode_d [NUM_CH];
  logic [7:0] level_q, level_d;
  logic [7:0] mode_eff_q, mode_eff_d;
  logic [7:0] active_q, active_d;
  logic [1:0] up_act_q, up_act_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0] start_q, start_d, stop_q, stop_d;
  logic [1:0] up_start_q, up_start_d;
  logic wr_start, wr_stop;

  assign wr_start = i_ce && i_wr && (i_addr == START_TRIGGER_ADDR);
  assign wr_stop = i_ce && i_wr && (i_addr == STOP_TRIGGER_ADDR);

  // ----------------------------------------
  // input synchronise and filter
  // ----------------------------------------
  logic [7:0] sync1_q, sync2_q, sync3_q, filt_q, cnt_clk_q;
  logic [7:0] cnt_clk_d, filt_d;
  logic [7:0] op_tick;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      op_tick[c] = i_op_clock_tick[{chmode_q[c][CLOCK_SELECT_HIGH_POS],
                                    chmode_q[c][CLOCK_SELECT_LOW_POS]}];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_in
      always_comb begin
        filt_d[g] = filt_q[g];
        if (op_tick[g]) begin
          if (!filt_en_q[g]) begin
            filt_d[g] = sync2_q[g]; // RULE7
          end else if (sync3_q[g] == sync2_q[g]) begin
            filt_d[g] = sync3_q[g]; // RULE6 RULE8
          end
        end
        // edge picked when count source bit is set, else operation clock
        if (chmode_q[g][COUNT_SOURCE_POS]) begin
          cnt_clk_d[g] = filt_d[g] & ~filt_q[g]; // RULE23
        end else begin
          cnt_clk_d[g] = op_tick[g]; // RULE23
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      filt_q <= 8'h00;
      cnt_clk_q <= 8'h00;
    end else if (i_ce) begin
      sync1_q <= i_timer_input_pin;
      sync2_q <= sync1_q;
      for (int c = 0; c < NUM_CH; c++) begin
        if (op_tick[c]) begin
          sync3_q[c] <= sync2_q[c];
        end
      end
      filt_q <= filt_d;
      cnt_clk_q <= cnt_clk_d;
    end
  end

  // ----------------------------------------
  // linking and outputs
  // ----------------------------------------
  // nearest master at or below each channel; masters never take from others
  logic [2:0] master_of [NUM_CH];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      master_of[c] = 3'(c);
      if (!i_master_sel[c] || (c % 2) != 0) begin
        for (int k = 0; k < c; k++) begin
          if (i_master_sel[k] && (k % 2) == 0) begin
            master_of[c] = 3'(k); // RULE13
          end
        end
      end
    end
  end

  always_comb begin
    mode_sel_d = mode_sel_q;
    pol_d = pol_q;
    oen_d = oen_q;
    filt_en_d = filt_en_q;
    level_d = level_q;
    mode_eff_d = mode_eff_q;
    active_d = active_q;
    up_act_d = up_act_q;
    start_d = 8'h00;
    stop_d = 8'h00;
    up_start_d = 2'b00;
    rdata_d = 16'h0000;
    for (int c = 0; c < NUM_CH; c++) begin
      chmode_d[c] = chmode_q[c];
    end
    if (i_wr) begin
      case (i_addr)
        OUTPUT_MODE_SELECT_ADDR: mode_sel_d = {8'h00, i_wdata[7:1], 1'b0};
        OUTPUT_POLARITY_ADDR: pol_d = {8'h00, i_wdata[7:1], 1'b0};
        OUTPUT_ENABLE_ADDR: oen_d = {8'h00, i_wdata[7:0]};
        INPUT_FILTER_ENABLE_ADDR: filt_en_d = i_wdata[7:0]; // RULE8
        default: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (i_addr == MODE_BASE_ADDR + 20'(2 * c)) begin
              chmode_d[c] = i_wdata;
            end
          end
        end
      endcase
    end
    // start and stop in one write keep linked channels in step
    if (wr_start) begin
      start_d = i_wdata[7:0];
      active_d = active_q | i_wdata[7:0];
    end
    if (wr_stop) begin
      stop_d = i_wdata[7:0];
      active_d = active_d & ~i_wdata[7:0];
    end
    // upper halves only in split mode
    for (int u = 0; u < 2; u++) begin
      if (chmode_q[2 * u + 1][SPLIT_BYTE_POS]) begin // RULE18 RULE21
        if (wr_start && i_wdata[UPPER_CH1_POS + 2 * u]) begin
          up_act_d[u] = 1'b1; // RULE20
          up_start_d[u] = 1'b1; // RULE19
        end
        if (wr_stop && i_wdata[UPPER_CH1_POS + 2 * u]) begin
          up_act_d[u] = 1'b0; // RULE20
        end
      end
    end
    // output waveform
    for (int c = 0; c < NUM_CH; c++) begin
      logic set_ev, rst_ev;
      set_ev = 1'b0;
      rst_ev = 1'b0;
      if (oen_q[c]) begin
        if (i_channel_interrupt[master_of[c]] && master_of[c] != 3'(c)) begin
          set_ev = 1'b1;
        end
        if (i_channel_interrupt[c]) begin
          rst_ev = 1'b1;
        end
        if (set_ev || rst_ev) begin
          mode_eff_d[c] = mode_sel_q[c]; // RULE5
          if (!mode_eff_d[c]) begin
            if (rst_ev) begin
              level_d[c] = ~level_q[c]; // RULE3
            end
          end else if (rst_ev) begin
            level_d[c] = 1'b0; // RULE4
          end else begin
            level_d[c] = 1'b1; // RULE4
          end
        end
      end
    end
    if (i_rd) begin
      case (i_addr)
        OUTPUT_MODE_SELECT_ADDR: rdata_d = mode_sel_q;
        OUTPUT_POLARITY_ADDR: rdata_d = pol_q;
        OUTPUT_ENABLE_ADDR: rdata_d = oen_q;
        INPUT_FILTER_ENABLE_ADDR: rdata_d = {8'h00, filt_en_q};
        ACTIVE_STATUS_ADDR: rdata_d = {4'h0, up_act_q[1], 1'b0, up_act_q[0], 1'b0, active_q};
        OUTPUT_LEVEL_ADDR: rdata_d = {8'h00, level_q};
        default: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (i_addr == MODE_BASE_ADDR + 20'(2 * c)) begin
              rdata_d = chmode_q[c];
            end
          end
        end
      endcase
    end
  end

  // polarity sampled only when the raw level changes
  logic [7:0] out_d, pol_eff_q, pol_eff_d;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pol_eff_d[c] = (level_d[c] != level_q[c]) ? pol_q[c] : pol_eff_q[c]; // RULE2
      out_d[c] = level_d[c] ^ pol_eff_d[c]; // RULE1
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mode_sel_q <= OUTPUT_MODE_SELECT_RST;
      pol_q <= REG16_RST;
      oen_q <= REG16_RST;
      filt_en_q <= INPUT_FILTER_ENABLE_RST;
      level_q <= 8'h00;
      mode_eff_q <= 8'h00;
      pol_eff_q <= 8'h00;
      active_q <= 8'h00;
      up_act_q <= 2'b00;
      rdata_q <= 16'h0000;
      start_q <= 8'h00;
      stop_q <= 8'h00;
      up_start_q <= 2'b00;
      o_timer_out <= 8'h00;
      o_upper_tick <= 2'b00;
      for (int c = 0; c < NUM_CH; c++) begin
        chmode_q[c] <= REG16_RST;
      end
    end else if (i_ce) begin
      mode_sel_q <= mode_sel_d;
      pol_q <= pol_d;
      oen_q <= oen_d;
      filt_en_q <= filt_en_d;
      level_q <= level_d;
      mode_eff_q <= mode_eff_d;
      pol_eff_q <= pol_eff_d;
      active_q <= active_d;
      up_act_q <= up_act_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      stop_q <= stop_d;
      up_start_q <= up_start_d;
      o_timer_out <= out_d;
      // upper half runs on the lower half's selected clock
      o_upper_tick <= {op_tick[3] & up_act_d[1], op_tick[1] & up_act_d[0]}; // RULE20
      for (int c = 0; c < NUM_CH; c++) begin
        chmode_q[c] <= chmode_d[c];
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_count_clock = cnt_clk_q;
  assign o_start_pulse = start_q;
  assign o_stop_pulse = stop_q;
  assign o_active = active_q;
  assign o_upper_active = up_act_q;
  assign o_upper_start_irq = up_start_q;
endmodule : timer_link

// >>> tb/timer_link_asserts.sv
`timescale 1ns/1ps
module timer_link_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // register port
  input wire logic [timer_link_pkg::ADDR_W-1:0] i_addr,
  input wire logic [timer_link_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [timer_link_pkg::DATA_W-1:0] o_rdata,
  // trigger outputs
  input wire logic [timer_link_pkg::NUM_CH-1:0] o_start_pulse,
  input wire logic [timer_link_pkg::NUM_CH-1:0] o_stop_pulse,
  input wire logic [timer_link_pkg::NUM_CH-1:0] o_active
);
  import timer_link_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic st;
  logic sp;
  logic rm;
  assign st = i_wr && i_ce && i_addr == START_TRIGGER_ADDR;
  assign sp = i_wr && i_ce && i_addr == STOP_TRIGGER_ADDR;
  assign rm = i_rd && i_ce && i_addr == OUTPUT_MODE_SELECT_ADDR;
  a_start_pulse_data: assert property (st |=> o_start_pulse == $past(i_wdata[7:0]))
    else $error("start pulse does not follow write");
  a_start_pulse_idle: assert property (i_ce && !st |=> o_start_pulse == 8'h00)
    else $error("start pulse without write");
  a_stop_pulse_data: assert property (sp |=> o_stop_pulse == $past(i_wdata[7:0]))
    else $error("stop pulse does not follow write");
  a_stop_pulse_idle: assert property (i_ce && !sp |=> o_stop_pulse == 8'h00)
    else $error("stop pulse without write");
  a_start_sets_active: assert property (st |=> (o_active & $past(i_wdata[7:0])) ==
    $past(i_wdata[7:0])) else $error("start did not set status");
  a_stop_clears_active: assert property (sp |=>
    (o_active & $past(i_wdata[7:0])) == 8'h00) else $error("stop did not clear status");
  // read data returns to zero after any enabled cycle without a read
  a_read_idle_zero: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_mode_rsvd_zero: assert property (rm |=> (o_rdata & 16'hFF01) == 16'h0000)
    else $error("reserved mode bits read as one");
  c_start: cover property (st);
  c_stop: cover property (sp);
  c_mode_read: cover property (rm);
endmodule : timer_link_asserts

bind timer_link timer_link_asserts u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_start_pulse(o_start_pulse), .o_stop_pulse(o_stop_pulse), .o_active(o_active));

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import timer_link_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [19:0] i_addr = 20'h00000;
  logic [15:0] i_wdata = 16'h0000;
  logic [7:0] irq = 8'h00;
  logic [7:0] msel = 8'h00;
  logic [7:0] pin = 8'h00;
  logic [15:0] o_rdata;
  logic [7:0] tout, cclk, spul, tpul, act;
  logic [1:0] uact, utick, uirq;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr = 32'h5603574A;
  int failures = 0;
  int check_count = 0;
  int c;
  timer_link dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_channel_interrupt(irq), .i_master_sel(msel), .i_op_clock_tick(4'hF),
    .i_timer_input_pin(pin), .o_timer_out(tout), .o_count_clock(cclk),
    .o_start_pulse(spul), .o_stop_pulse(tpul), .o_active(act),
    .o_upper_active(uact), .o_upper_tick(utick), .o_upper_start_irq(uirq));
  initial forever #20 i_clk = ~i_clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask : wr
  // read expectations queue up; the monitor pops one per answer
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [7:0] m);
    @(posedge i_clk) irq <= m;
    @(posedge i_clk) irq <= 8'h00;
    @(negedge i_clk);
  endtask : pulse
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  always @(posedge i_clk) rd_d <= i_rd;
  // sampled mid-cycle so the registered answer has settled
  always @(negedge i_clk) if (rd_d) chk(o_rdata, exp_q.pop_front());
  initial begin
    repeat (2000) @(posedge i_clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(OUTPUT_MODE_SELECT_ADDR, OUTPUT_MODE_SELECT_RST);
    rd(INPUT_FILTER_ENABLE_ADDR, {8'h00, INPUT_FILTER_ENABLE_RST});
    rd(20'hF0000, 16'h0000);
    for (int n = 0; n < 4; n++) begin
      lfsr = nxt(lfsr);
      wr(OUTPUT_MODE_SELECT_ADDR, lfsr[15:0]);
      rd(OUTPUT_MODE_SELECT_ADDR, lfsr[15:0] & 16'h00FE);
      wr(INPUT_FILTER_ENABLE_ADDR, lfsr[31:16]);
      rd(INPUT_FILTER_ENABLE_ADDR, {8'h00, lfsr[23:16]});
    end
    $display("test registers done");
    wr(OUTPUT_MODE_SELECT_ADDR, 16'h0008);
    wr(OUTPUT_POLARITY_ADDR, 16'h0000);
    wr(OUTPUT_ENABLE_ADDR, 16'h00FF);
    msel <= 8'h05;
    pulse(8'h02); chk(tout, 8'h02);
    pulse(8'h02); chk(tout, 8'h00);
    pulse(8'h04); chk(tout, 8'h0C);
    pulse(8'h08); chk(tout, 8'h04);
    wr(OUTPUT_POLARITY_ADDR, 16'h0002);
    @(negedge i_clk) chk(tout, 8'h04);
    pulse(8'h02); chk(tout, 8'h04);
    pulse(8'h02); chk(tout, 8'h06);
    $display("test outputs done");
    // a write while the enable is low must leave the register alone
    @(posedge i_clk) ce <= 1'b0;
    wr(OUTPUT_ENABLE_ADDR, 16'h0000);
    @(posedge i_clk) ce <= 1'b1;
    rd(OUTPUT_ENABLE_ADDR, 16'h00FF);
    $display("test enable done");
    wr(START_TRIGGER_ADDR, 16'h0A03);
    @(negedge i_clk) chk(spul, 8'h03);
    chk(act, 8'h03);
    chk(uact, 2'b00);
    wr(MODE_BASE_ADDR + 20'h00002, 16'h0800);
    wr(START_TRIGGER_ADDR, 16'h0200);
    @(negedge i_clk) chk(uact, 2'b01);
    chk({uirq, utick}, 4'h5);
    wr(STOP_TRIGGER_ADDR, 16'h0203);
    @(negedge i_clk) chk(uact, 2'b00);
    chk({tpul, act}, 16'h0300);
    chk({uirq, utick}, 4'h0);
    $display("test triggers done");
    wr(MODE_BASE_ADDR, 16'h1000);
    wr(START_TRIGGER_ADDR, 16'h0001);
    // a one-cycle glitch must pass unfiltered and be dropped when filtered
    for (int f = 0; f < 3; f++) begin
      wr(INPUT_FILTER_ENABLE_ADDR, {15'h0000, f != 0});
      c = 0;
      @(posedge i_clk) pin <= 8'h01;
      // count from the pulse on: the edge can come and go before the pin drops
      for (int k = 0; k < 14; k++) begin
        @(posedge i_clk) if (k == (f == 2 ? 4 : 0)) pin <= 8'h00;
        @(negedge i_clk) if (cclk[0] === 1'b1) c++;
      end
      chk(16'(c), {15'h0000, f != 1});
    end
    $display("test filter done");
    close_out();
  end
endmodule : tb
